/* File: src/phy_mii_register_bank.sv */
// AXI4-Lite slave holding the PHY management register bank
// Contract
// - Control bit 14 loops host transmit through the PHY; resets 0.
// - Control bit 13 forces 100 (1) or 10 Mbps without negotiation.
// - Control bit 12 enables negotiation; resets to 1.
// - Writing 1 to control bit 9 restarts negotiation; resets 0.
// - Control bit 8 selects full duplex; resets to 1.
// - Control bit 5 picks the crossover algorithm variant; resets to 1.
// - Control bit 4 forces MDI (1) or MDI-X (0); resets 0.
// - Control bit 3 disables automatic crossover; resets 0.
// - Control bit 1 disables the transmitter; resets 0.
// - Control bit 0 turns off all port LEDs; resets 0.
// - Aliased fields share one flop with the port control register.
// - Status bits 15..11 read fixed capabilities 0,0,1,1,0.
// - Status bit 5 shows negotiation complete, mirrored in port status.
// - Status bit 3, negotiation capable, reads 0.
// - Status bit 2 shows link up, mirrored in port status.
// - Status bit 0, extended capability, reads 0.
// - Two read-only identifier words ignore writes.
// - Advertisement bit 10 offers pause; writable, resets to 1.
// - Advertisement bits 8..5 offer four abilities; writable, reset 1.
// - Partner bit 10 shows partner pause; read-only, resets 0.
// - Partner bits 8..5 show partner abilities; read-only, reset 0.
`timescale 1ns/1ps
`default_nettype none
module phy_mii_register_bank #(
  parameter logic [15:0] IDENT_LOW_VALUE = 16'h5A00, // Arbitrary value
  parameter logic [15:0] IDENT_HIGH_VALUE = 16'h00A5 // Arbitrary value
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [phy_mii_regs_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [phy_mii_regs_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // PHY status, from the PHY clock domain
  input wire logic an_complete,
  input wire logic link_up,
  input wire logic partner_pause,
  input wire logic [3:0] partner_abilities,
  // PHY control
  output logic host_side_loopback,
  output logic force_100,
  output logic an_enable,
  output logic an_restart_pulse,
  output logic force_full_duplex,
  output logic crossover_variant_select,
  output logic force_mdi,
  output logic auto_mdix_disable,
  output logic tx_disable,
  output logic led_off,
  output logic adv_pause,
  output logic [3:0] adv_abilities
);
  import phy_mii_regs_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic aw_have;
    logic [IDX_W-1:0] aw_idx;
    logic w_have;
    logic [15:0] w_data;
    logic [1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] sync3;
    logic [6:0] phy_stat; // {an_done, link, pause, abilities}
    logic loopback;
    logic force_100;
    logic an_en;
    logic an_restart;
    logic full_dup;
    logic xvar;
    logic force_mdi;
    logic mdix_dis;
    logic tx_dis;
    logic led_off;
    logic [2:0] ctl_rsv; // Control bits 11, 10, 2
    logic [2:0] pc_rsv; // Port control bits 12, 11, 8
    logic adv_pause;
    logic adv_rsv;
    logic [3:0] adv_abil;
    logic restart_pulse;
  } state_s;

  state_s q, d;
  logic aw_fire, w_fire, ar_fire, wr_go;
  logic [15:0] nw;

  // ------------------------------------------------------------------
  // Word builders and decoding
  // ------------------------------------------------------------------
  // Byte-lane merge of a 16-bit write into the current word
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [1:0] st);
    merge = old;
    if (st[0]) begin
      merge[7:0] = wd[7:0];
    end
    if (st[1]) begin
      merge[15:8] = wd[15:8];
    end
  endfunction

  function automatic logic [15:0] basic_control(input state_s s);
    basic_control = 16'h0000;
    basic_control[BC_LOOPBACK] = s.loopback;
    basic_control[BC_FORCE_100] = s.force_100;
    basic_control[BC_AN_ENABLE] = s.an_en;
    basic_control[BC_RSV_HI] = s.ctl_rsv[2];
    basic_control[BC_RSV_LO] = s.ctl_rsv[1];
    basic_control[BC_AN_RESTART] = s.an_restart;
    basic_control[BC_FULL_DUPLEX] = s.full_dup;
    basic_control[BC_XOVER_VARIANT] = s.xvar;
    basic_control[BC_FORCE_MDI] = s.force_mdi;
    basic_control[BC_MDIX_DISABLE] = s.mdix_dis;
    basic_control[BC_RSV_2] = s.ctl_rsv[0];
    basic_control[BC_TX_DISABLE] = s.tx_dis;
    basic_control[BC_LED_OFF] = s.led_off;
  endfunction

  function automatic logic [15:0] port_control(input state_s s);
    port_control = 16'h0000;
    port_control[PC_LED_OFF] = s.led_off;
    port_control[PC_TX_DISABLE] = s.tx_dis;
    port_control[PC_AN_RESTART] = s.an_restart;
    port_control[PC_RSV_12] = s.pc_rsv[2];
    port_control[PC_RSV_11] = s.pc_rsv[1];
    port_control[PC_MDIX_DISABLE] = s.mdix_dis;
    port_control[PC_FORCE_MDI] = s.force_mdi;
    port_control[PC_RSV_8] = s.pc_rsv[0];
    port_control[PC_AN_ENABLE] = s.an_en;
    port_control[PC_FORCE_100] = s.force_100;
    port_control[PC_FULL_DUPLEX] = s.full_dup;
    port_control[PC_ADV_PAUSE] = s.adv_pause;
    port_control[3:0] = s.adv_abil;
  endfunction

  // Selector field is a constant; reserved bit 9 is held in a flop and takes writes
  function automatic logic [15:0] advert(input state_s s);
    advert = SELECTOR_FIXED;
    advert[AD_PAUSE] = s.adv_pause;
    advert[AD_RSV_9] = s.adv_rsv;
    advert[AD_ABIL_LO+3:AD_ABIL_LO] = s.adv_abil;
  endfunction

  function automatic logic [15:0] read_word(input logic [IDX_W-1:0] idx,
                                            input state_s s);
    read_word = 16'h0000;
    case (idx)
      IDX_BASIC_CONTROL: read_word = basic_control(s);
      IDX_BASIC_STATUS: begin
        read_word = BS_FIXED;
        read_word[BS_AN_DONE] = s.phy_stat[6];
        read_word[BS_LINK_UP] = s.phy_stat[5];
      end
      IDX_IDENT_LOW: read_word = IDENT_LOW_VALUE;
      IDX_IDENT_HIGH: read_word = IDENT_HIGH_VALUE;
      IDX_ADVERT: read_word = advert(s);
      IDX_PARTNER: begin
        read_word = SELECTOR_FIXED;
        read_word[AD_PAUSE] = s.phy_stat[4];
        read_word[AD_ABIL_LO+3:AD_ABIL_LO] = s.phy_stat[3:0];
      end
      IDX_PORT_CONTROL: read_word = port_control(s);
      IDX_PORT_STATUS: begin
        read_word[PS_XOVER_VARIANT] = s.xvar;
        read_word[PS_AN_DONE] = s.phy_stat[6];
        read_word[PS_LINK_UP] = s.phy_stat[5];
        read_word[PS_PAUSE:0] = s.phy_stat[4:0];
      end
      default: read_word = 16'h0000;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_BASIC_CONTROL, IDX_BASIC_STATUS, IDX_IDENT_LOW, IDX_IDENT_HIGH,
      IDX_ADVERT, IDX_PARTNER, IDX_PORT_CONTROL, IDX_PORT_STATUS:
        is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Handshakes
  // ------------------------------------------------------------------
  // A channel stays closed while its item waits or a response is owed
  assign awready = !q.aw_have && !q.bvalid;
  assign wready = !q.w_have && !q.bvalid;
  assign arready = !q.rvalid;
  assign aw_fire = awvalid && awready;
  assign w_fire = wvalid && wready;
  assign ar_fire = arvalid && arready;
  assign wr_go = q.aw_have && q.w_have && !q.bvalid;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    d = q;
    nw = 16'h0000;
    d.restart_pulse = 1'b0;
    // PHY status crosses in; a bit moves only when stages 2 and 3 agree
    d.sync1 = {an_complete, link_up, partner_pause, partner_abilities};
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    for (int i = 0; i < 7; i++) begin
      if (q.sync2[i] == q.sync3[i]) begin
        d.phy_stat[i] = q.sync3[i];
      end
    end
    if (aw_fire) begin
      d.aw_have = 1'b1;
      d.aw_idx = awaddr[ADDR_W-1:2];
    end
    if (w_fire) begin
      d.w_have = 1'b1;
      d.w_data = wdata[15:0];
      d.w_strb = wstrb[1:0];
    end
    // Commit once address and data are both held
    if (wr_go) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = is_mapped(q.aw_idx) ? RESP_OKAY : RESP_SLVERR;
      case (q.aw_idx)
        IDX_BASIC_CONTROL: begin
          nw = merge(basic_control(q), q.w_data, q.w_strb);
          d.loopback = nw[BC_LOOPBACK];
          d.force_100 = nw[BC_FORCE_100];
          d.an_en = nw[BC_AN_ENABLE];
          d.an_restart = nw[BC_AN_RESTART];
          d.restart_pulse = q.w_strb[1] && nw[BC_AN_RESTART];
          d.full_dup = nw[BC_FULL_DUPLEX];
          d.xvar = nw[BC_XOVER_VARIANT];
          d.force_mdi = nw[BC_FORCE_MDI];
          d.mdix_dis = nw[BC_MDIX_DISABLE];
          d.tx_dis = nw[BC_TX_DISABLE];
          d.led_off = nw[BC_LED_OFF];
          d.ctl_rsv = {nw[BC_RSV_HI], nw[BC_RSV_LO], nw[BC_RSV_2]};
        end
        // Same flops as the basic control fields, and bits 4..0 as the advertisement fields
        IDX_PORT_CONTROL: begin
          nw = merge(port_control(q), q.w_data, q.w_strb);
          d.led_off = nw[PC_LED_OFF];
          d.tx_dis = nw[PC_TX_DISABLE];
          d.an_restart = nw[PC_AN_RESTART];
          d.restart_pulse = q.w_strb[1] && nw[PC_AN_RESTART];
          d.mdix_dis = nw[PC_MDIX_DISABLE];
          d.force_mdi = nw[PC_FORCE_MDI];
          d.an_en = nw[PC_AN_ENABLE];
          d.force_100 = nw[PC_FORCE_100];
          d.full_dup = nw[PC_FULL_DUPLEX];
          d.adv_pause = nw[PC_ADV_PAUSE];
          d.adv_abil = nw[3:0];
          d.pc_rsv = {nw[PC_RSV_12], nw[PC_RSV_11], nw[PC_RSV_8]};
        end
        IDX_ADVERT: begin
          nw = merge(advert(q), q.w_data, q.w_strb);
          d.adv_pause = nw[AD_PAUSE];
          d.adv_rsv = nw[AD_RSV_9];
          d.adv_abil = nw[AD_ABIL_LO+3:AD_ABIL_LO];
        end
        IDX_PORT_STATUS: begin
          if (q.w_strb[1]) begin
            d.xvar = q.w_data[PS_XOVER_VARIANT];
          end
        end
        default: nw = 16'h0000; // Read-only words ignore writes
      endcase
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (ar_fire) begin
      d.rvalid = 1'b1;
      d.rdata = read_word(araddr[ADDR_W-1:2], q);
      d.rresp = is_mapped(araddr[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
    end else if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    // Synchronous reset; the control fields take their defaults
    if (!aresetn) begin
      d = '0;
      d.loopback = RST_LOOPBACK;
      d.force_100 = RST_FORCE_100;
      d.an_en = RST_AN_ENABLE;
      d.an_restart = RST_AN_RESTART;
      d.full_dup = RST_FULL_DUPLEX;
      d.xvar = RST_XOVER_VARIANT;
      d.force_mdi = RST_FORCE_MDI;
      d.mdix_dis = RST_MDIX_DISABLE;
      d.tx_dis = RST_TX_DISABLE;
      d.led_off = RST_LED_OFF;
      d.adv_pause = RST_ADV_PAUSE;
      d.adv_abil = RST_ADV_ABIL;
    end
  end

  // Single state register
  always_ff @(posedge aclk) begin
    q <= d;
  end

  // ------------------------------------------------------------------
  // Outputs, all straight from flops
  // ------------------------------------------------------------------
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign rvalid = q.rvalid;
  assign rdata = {16'h0000, q.rdata};
  assign rresp = q.rresp;
  assign host_side_loopback = q.loopback;
  assign force_100 = q.force_100;
  assign an_enable = q.an_en;
  assign an_restart_pulse = q.restart_pulse;
  assign force_full_duplex = q.full_dup;
  assign crossover_variant_select = q.xvar;
  assign force_mdi = q.force_mdi;
  assign auto_mdix_disable = q.mdix_dis;
  assign tx_disable = q.tx_dis;
  assign led_off = q.led_off;
  assign adv_pause = q.adv_pause;
  assign adv_abilities = q.adv_abil;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_loopback_write: assert property (
    wr_go && q.aw_idx == IDX_BASIC_CONTROL && q.w_strb[1]
    |=> host_side_loopback == $past(q.w_data[BC_LOOPBACK]) && bvalid)
    else $error("loopback bit not taken from write");
  a_reset_defaults: assert property (
    $rose(aresetn) |-> force_100 && an_enable && force_full_duplex &&
      crossover_variant_select && !host_side_loopback && !tx_disable &&
      !led_off && adv_pause && adv_abilities == 4'hF)
    else $error("control defaults wrong after reset");
  a_restart_pulse: assert property (
    wr_go && q.aw_idx == IDX_BASIC_CONTROL && q.w_strb[1] &&
      q.w_data[BC_AN_RESTART]
    |=> an_restart_pulse ##1 !an_restart_pulse)
    else $error("restart pulse not one cycle");
  a_alias_share: assert property (
    wr_go && q.aw_idx == IDX_PORT_CONTROL && q.w_strb[0]
    |=> an_enable == $past(q.w_data[PC_AN_ENABLE]) &&
      force_full_duplex == $past(q.w_data[PC_FULL_DUPLEX]))
    else $error("alias write not seen at basic control");
  a_status_read: assert property (
    ar_fire && araddr[ADDR_W-1:2] == IDX_BASIC_STATUS
    |=> rvalid && rdata[15:11] == 5'h06 && !rdata[3] && !rdata[0] &&
      rdata[5] == $past(q.phy_stat[6]) && rdata[2] == $past(q.phy_stat[5]))
    else $error("basic status read wrong");
  a_ident_fixed: assert property (
    ar_fire && araddr[ADDR_W-1:2] == IDX_IDENT_LOW
    |=> rvalid && rdata == {16'h0000, IDENT_LOW_VALUE} && rresp == RESP_OKAY)
    else $error("identifier low read wrong");
  a_partner_read: assert property (
    ar_fire && araddr[ADDR_W-1:2] == IDX_PARTNER
    |=> rdata[10] == $past(q.phy_stat[4]) &&
      rdata[8:5] == $past(q.phy_stat[3:0]) && rdata[4:0] == 5'h01)
    else $error("partner ability read wrong");
  a_tx_led_write: assert property (
    wr_go && q.aw_idx == IDX_BASIC_CONTROL && q.w_strb[0]
    |=> tx_disable == $past(q.w_data[BC_TX_DISABLE]) &&
      led_off == $past(q.w_data[BC_LED_OFF]))
    else $error("transmit or LED disable not taken");
  a_unmapped_err: assert property (
    wr_go && !is_mapped(q.aw_idx) |=> bvalid && bresp == RESP_SLVERR)
    else $error("unmapped write not refused");

endmodule
`default_nettype wire

/* File: src/phy_mii_regs_pkg.sv */
// Register map, field positions and reset values of the PHY management bank
package phy_mii_regs_pkg;

  // ------------------------------------------------------------------
  // Bus geometry and answers
  // ------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_BASIC_CONTROL = 10'h0E4;
  localparam logic [IDX_W-1:0] IDX_BASIC_STATUS = 10'h0E6;
  localparam logic [IDX_W-1:0] IDX_IDENT_LOW = 10'h0E8;
  localparam logic [IDX_W-1:0] IDX_IDENT_HIGH = 10'h0EA;
  localparam logic [IDX_W-1:0] IDX_ADVERT = 10'h0EC;
  localparam logic [IDX_W-1:0] IDX_PARTNER = 10'h0EE;
  localparam logic [IDX_W-1:0] IDX_PORT_CONTROL = 10'h0F6;
  localparam logic [IDX_W-1:0] IDX_PORT_STATUS = 10'h0F8;

  // ------------------------------------------------------------------
  // Basic control fields
  // ------------------------------------------------------------------
  localparam int BC_LOOPBACK = 14;
  localparam int BC_FORCE_100 = 13;
  localparam int BC_AN_ENABLE = 12;
  localparam int BC_RSV_HI = 11;
  localparam int BC_RSV_LO = 10;
  localparam int BC_AN_RESTART = 9;
  localparam int BC_FULL_DUPLEX = 8;
  localparam int BC_XOVER_VARIANT = 5;
  localparam int BC_FORCE_MDI = 4;
  localparam int BC_MDIX_DISABLE = 3;
  localparam int BC_RSV_2 = 2;
  localparam int BC_TX_DISABLE = 1;
  localparam int BC_LED_OFF = 0;

  // ------------------------------------------------------------------
  // Port control alias fields
  // ------------------------------------------------------------------
  localparam int PC_LED_OFF = 15;
  localparam int PC_TX_DISABLE = 14;
  localparam int PC_AN_RESTART = 13;
  localparam int PC_RSV_12 = 12;
  localparam int PC_RSV_11 = 11;
  localparam int PC_MDIX_DISABLE = 10;
  localparam int PC_FORCE_MDI = 9;
  localparam int PC_RSV_8 = 8;
  localparam int PC_AN_ENABLE = 7;
  localparam int PC_FORCE_100 = 6;
  localparam int PC_FULL_DUPLEX = 5;
  localparam int PC_ADV_PAUSE = 4;

  // ------------------------------------------------------------------
  // Status, advertisement and partner fields
  // ------------------------------------------------------------------
  localparam logic [15:0] BS_FIXED = 16'h3050; // 13,12,6,4 set
  localparam int BS_AN_DONE = 5;
  localparam int BS_LINK_UP = 2;
  localparam int PS_XOVER_VARIANT = 15;
  localparam int PS_AN_DONE = 6;
  localparam int PS_LINK_UP = 5;
  localparam int PS_PAUSE = 4;
  localparam int AD_PAUSE = 10;
  localparam int AD_RSV_9 = 9;
  localparam int AD_ABIL_LO = 5;
  localparam logic [15:0] SELECTOR_FIXED = 16'h0001;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic RST_LOOPBACK = 1'b0;
  localparam logic RST_FORCE_100 = 1'b1;
  localparam logic RST_AN_ENABLE = 1'b1;
  localparam logic RST_AN_RESTART = 1'b0;
  localparam logic RST_FULL_DUPLEX = 1'b1;
  localparam logic RST_XOVER_VARIANT = 1'b1;
  localparam logic RST_FORCE_MDI = 1'b0;
  localparam logic RST_MDIX_DISABLE = 1'b0;
  localparam logic RST_TX_DISABLE = 1'b0;
  localparam logic RST_LED_OFF = 1'b0;
  localparam logic RST_ADV_PAUSE = 1'b1;
  localparam logic [3:0] RST_ADV_ABIL = 4'hF;

endpackage

/* File: tb/link_partner_model.sv */
// Behavioural remote link partner feeding negotiated status to the bank
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
  // Clock
  input wire logic aclk,
  // Cable state and offered abilities chosen by the bench
  input wire logic cable_in,
  input wire logic [4:0] offer,
  // Status seen by the device
  output logic link_up,
  output logic an_complete,
  output logic partner_pause,
  output logic [3:0] partner_abilities
);
  // ------------------------------------------------------------------
  // Negotiation follows link by a cycle, like a real partner
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    link_up <= cable_in;
    an_complete <= cable_in & link_up;
    // Abilities vanish with the cable, they never hold stale values
    {partner_pause, partner_abilities} <= cable_in ? offer : 5'h00;
  end
endmodule
`default_nettype wire

/* File: tb/phy_mii_register_bank_tb.sv */
// Self-checking bench for the PHY management register bank
`timescale 1ns/1ps
`default_nettype none
module phy_mii_register_bank_tb;
  import phy_mii_regs_pkg::*;
  localparam logic [15:0] ID_LO = 16'h6C3B; // Arbitrary value
  localparam logic [15:0] ID_HI = 16'h0C5E; // Arbitrary value
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, cable_in;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, partner_abilities, adv_abilities;
  logic [1:0] bresp, rresp, rs;
  logic an_complete, link_up, partner_pause, adv_pause, an_restart_pulse;
  logic [4:0] offer;
  logic [8:0] ctl_out;
  logic [15:0] d, c;
  int failures, checks, cyc, pulses;
  int seed = 4;
  // ------------------------------------------------------------------
  // Device, partner and clock
  // ------------------------------------------------------------------
  phy_mii_register_bank #(.IDENT_LOW_VALUE(ID_LO), .IDENT_HIGH_VALUE(ID_HI))
  u_phy_mii_register_bank (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .an_complete(an_complete), .link_up(link_up),
    .partner_pause(partner_pause), .partner_abilities(partner_abilities),
    .host_side_loopback(ctl_out[8]), .force_100(ctl_out[7]),
    .an_enable(ctl_out[6]), .an_restart_pulse(an_restart_pulse),
    .force_full_duplex(ctl_out[5]), .crossover_variant_select(ctl_out[4]),
    .force_mdi(ctl_out[3]), .auto_mdix_disable(ctl_out[2]),
    .tx_disable(ctl_out[1]), .led_off(ctl_out[0]),
    .adv_pause(adv_pause), .adv_abilities(adv_abilities));
  link_partner_model u_link_partner_model (.aclk(aclk), .cable_in(cable_in),
    .offer(offer), .link_up(link_up), .an_complete(an_complete),
    .partner_pause(partner_pause), .partner_abilities(partner_abilities));
  initial begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end
  // Restart pulses counted, since a one-cycle pulse is easy to miss
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (an_restart_pulse === 1'b1) pulses <= pulses + 1;
    if (cyc == 5000) begin
      failures++;
      complete_run();
    end
  end
  // ------------------------------------------------------------------
  // Bus tasks, comparison and closing
  // ------------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [15:0] v,
                    input logic [3:0] s = 4'hF);
    logic ap, wp;
    ap = 1;
    wp = 1;
    awaddr <= a;
    wdata <= {16'h0000, v};
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    while (ap || wp) begin
      @(posedge aclk);
      if (ap && awready) begin ap = 0; awvalid <= 0; end
      if (wp && wready) begin wp = 0; wvalid <= 0; end
    end
    bready <= 1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 0;
  endtask
  task automatic rdr(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    rready <= 1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 0;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Port control alias image of a basic control value, adverts at reset
  function automatic logic [15:0] to_port(input logic [15:0] v);
    return {v[0], v[1], v[9], 2'b00, v[3], v[4], 1'b0, v[12], v[13], v[8],
            5'h1F};
  endfunction
  function automatic logic [15:0] to_ctl(input logic [15:0] v);
    return {2'b00, v[6], v[7], 2'b00, v[13], v[5], 3'b000, v[9], v[10],
            1'b0, v[14], v[15]};
  endfunction
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, cable_in} = '0;
    {awaddr, araddr, wdata, wstrb, offer} = '0;
    aresetn = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rdr(12'h390); chk(rd, 32'h3120);
    chk(ctl_out, 9'h0F0);
    rdr(12'h398); chk(rd, 32'h3050);
    rdr(12'h3A0); chk(rd, ID_LO);
    rdr(12'h3B0); chk(rd, 32'h05E1);
    rdr(12'h3B8); chk(rd, 32'h0001);
    $display("Test reset values finished");
    // Read-only words take writes with OKAY and keep their values
    wr(12'h3A8, ~ID_HI); chk(rs, RESP_OKAY);
    rdr(12'h3A8); chk(rd, ID_HI);
    wr(12'h398, 16'hFFFF); rdr(12'h398); chk(rd, 32'h3050);
    wr(12'h3B8, 16'hFFFF); rdr(12'h3B8); chk(rd, 32'h0001);
    rdr(12'h3C0); chk(rs, RESP_SLVERR);
    chk(rd, 32'h0);
    wr(12'h3C0, 16'hFFFF); chk(rs, RESP_SLVERR);
    $display("Test read-only and unmapped finished");
    // Eight control writes, each read back at both words, all ones first as a corner
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? 16'hFFFF : 16'($random(seed));
      d = 16'(pulses);
      wr(12'h390, c);
      @(posedge aclk);
      chk(16'(pulses) - d, c[9]);
      chk(ctl_out, {c[14:12], c[8], c[5:3], c[1:0]});
      rdr(12'h390); chk(rd, c & 16'h7F3F);
      rdr(12'h3D8); chk(rd, to_port(c));
    end
    // Lane 1 only clears the high byte, the low byte keeps its bits
    wr(12'h390, 16'h0000, 4'h2);
    rdr(12'h390); chk(rd, c & 16'h003F);
    c = c & 16'h003F;
    $display("Test control writes finished");
    d = 16'($random(seed));
    wr(12'h3D8, d);
    rdr(12'h390); chk(rd, (c & 16'h4C24) | to_ctl(d));
    rdr(12'h3B0); chk(rd, {d[4], 1'b0, d[3:0], 5'h01});
    rdr(12'h3E0); chk(rd[15], c[5]);
    d = 16'($random(seed));
    wr(12'h3B0, d);
    rdr(12'h3B0); chk(rd, (d & 16'h07E0) | 16'h0001);
    chk({adv_pause, adv_abilities}, {d[10], d[8:5]});
    $display("Test alias and advertisement finished");
    // Partner status, first case link up with every ability offered
    for (int i = 0; i < 6; i++) begin
      cable_in <= (i == 0) ? 1'b1 : 1'($random(seed));
      offer <= (i == 0) ? 5'h1F : 5'($random(seed));
      repeat (10) @(posedge aclk);
      rdr(12'h398); chk(rd, 16'h3050 | {cable_in, 2'b00, cable_in, 2'b00});
      rdr(12'h3B8); chk(rd, {offer[4] & cable_in, 1'b0, offer[3:0] & {4{cable_in}}, 5'h01});
      rdr(12'h3E0); chk(rd[6:0], {cable_in, cable_in, offer & {5{cable_in}}});
    end
    $display("Test partner status finished");
    complete_run();
  end
endmodule
`default_nettype wire
